// ### pkg/gst_pkg.sv
// constants, register map and clock-source codes of the gated sixteen bit timer
package gst_pkg;
  // clock timing
  localparam int CLK_PERIOD_NS = 10;                       // aclk is the oscillator
  localparam int INSTR_NS      = 40;                       // one instruction cycle
  localparam int INSTR_CYC     = INSTR_NS / CLK_PERIOD_NS; // oscillator cycles per instruction
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_CYC - 1);   // last phase of an instruction

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00; // timer_control_reg
  localparam logic [7:0] ADDR_CLK_SEL  = 8'h04; // timer_clock_select_reg
  localparam logic [7:0] ADDR_GATE_SEL = 8'h08; // timer_gate_control_reg
  localparam logic [7:0] ADDR_CNT_LO   = 8'h0C; // count_low_byte
  localparam logic [7:0] ADDR_CNT_HI   = 8'h10; // count_high_byte
  localparam logic [7:0] ADDR_STATUS   = 8'h14; // read-only state

  // control field positions
  localparam int CTRL_ON_BIT    = 0; // counter_on_bit
  localparam int CTRL_GE_BIT    = 1; // gate_enable_bit
  localparam int CTRL_ASYNC_BIT = 2; // external edges count at once instead of waiting for an instruction boundary
  localparam int CTRL_GPOL_BIT  = 3; // gate active level
  localparam int CTRL_PS_LSB    = 4; // two-bit prescale field, divide by 1,2,4,8

  // status field positions
  localparam int STAT_GATE_BIT  = 0;
  localparam int STAT_ARMED_BIT = 1;
  localparam int STAT_RUN_BIT   = 2;

  // reset values
  localparam logic [7:0]  CTRL_RST     = 8'h00;
  localparam logic [3:0]  CLK_SEL_RST  = 4'h1;
  localparam logic [3:0]  GATE_SEL_RST = 4'h0;
  localparam logic [15:0] CNT_RST      = 16'h0000;

  // clock source codes
  localparam logic [3:0] CS_EXT   = 4'h0; // external_count_input edges
  localparam logic [3:0] CS_FOSC4 = 4'h1; // instruction clock
  localparam logic [3:0] CS_FOSC  = 4'h2; // undivided oscillator

  // gate source count; the external clock input rides one bit above them
  localparam int GATE_SRCS = 14;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### hw/gst_sync2.sv
// two flip-flop synchroniser for a group of unrelated asynchronous levels
`timescale 1ns/1ps
module gst_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q; // first stage, read only by the second

  // each bit is an independent level, so no bus coherence is claimed
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= '0;
      dout   <= '0;
    end
    else
    begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // gst_sync2

// ### hw/gst_timer.sv
// gated sixteen bit timer with an AXI4-Lite register slave
//
// How it works
// - sixteen-bit count, byte writes update it immediately
// - internal source times instructions, external counts edges
// - on and gate-enable pick off, always-on, gated
// - four-bit field selects the counting clock source
// - internal clock divided by the prescaler
// - undivided oscillator adds four per instruction
// - gate chosen from many asynchronous event sources
// - first rising edge ignored until falling seen
// - external input counts on its rising edge
// - external input synchronised or free-running, selectable
`timescale 1ns/1ps
module gst_timer
  import gst_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address channel
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data channel
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response channel
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address channel
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data channel
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // asynchronous gate sources
  input  wire logic        gate_pin,
  input  wire logic        timer_zero_output,
  input  wire logic [1:0]  sibling_counter_output,
  input  wire logic [2:0]  period_timer_output,
  input  wire logic [1:0]  capture_compare_output,
  input  wire logic [1:0]  pulse_width_output,
  input  wire logic [1:0]  comparator_output,
  input  wire logic        zero_cross_output,
  // external clock pin
  input  wire logic        external_count_input
);
  // bus state
  logic        awready_q, awready_d;  // write handshake pulse
  logic        bvalid_q,  bvalid_d;   // write answer pending
  logic [1:0]  bresp_q,   bresp_d;
  logic        arready_q, arready_d;  // read handshake pulse
  logic        rvalid_q,  rvalid_d;   // read answer pending
  logic [31:0] rdata_q,   rdata_d;
  logic [1:0]  rresp_q,   rresp_d;
  logic [31:0] rd_mux;                // read data of araddr
  logic        rd_hit;                // araddr is mapped
  // timer state
  logic [7:0]  ctrl_q,     ctrl_d;     // timer_control_reg
  logic [3:0]  clk_sel_q,  clk_sel_d;  // timer_clock_select_reg
  logic [3:0]  gate_sel_q, gate_sel_d; // timer_gate_control_reg
  logic [15:0] cnt_q,      cnt_d;      // live count
  logic [1:0]  ic_q,       ic_d;       // instruction phase
  logic [2:0]  ps_q,       ps_d;       // prescaler count
  logic        ext_prev_q, ext_prev_d; // last synced external level
  logic        armed_q,    armed_d;    // falling edge seen
  logic        pend_q,     pend_d;     // synced edge waiting for instruction
  // decoded controls
  logic        wr_en, wr_lo, wr_hi, cnt_wr;
  logic        on_bit, ge_bit, async_bit, count_en, gate_act, src_tick, inc;
  logic [2:0]  ps_mask;
  logic        ext_rise, ext_fall, ext_s;
  logic [GATE_SRCS:0] sync_all; // gate sources plus external input

  // every asynchronous level passes two flip-flops before any logic
  gst_sync2 #(.W(GATE_SRCS + 1)) u_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .din     ({external_count_input, zero_cross_output, comparator_output,
                pulse_width_output, capture_compare_output, period_timer_output,
                sibling_counter_output, timer_zero_output, gate_pin}),
    .dout    (sync_all)
  );

  assign ext_s = sync_all[GATE_SRCS];

  // write lands in the cycle of the address and data handshake
  assign wr_en  = awready_q && s_axi_wstrb[0];
  assign wr_lo  = wr_en && (s_axi_awaddr == ADDR_CNT_LO);
  assign wr_hi  = wr_en && (s_axi_awaddr == ADDR_CNT_HI);
  assign cnt_wr = wr_lo || wr_hi;

  // read decode; unmapped addresses answer slave error with zero data
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      ADDR_CTRL:     rd_mux[7:0] = ctrl_q;
      ADDR_CLK_SEL:  rd_mux[3:0] = clk_sel_q;
      ADDR_GATE_SEL: rd_mux[3:0] = gate_sel_q;
      ADDR_CNT_LO:   rd_mux[7:0] = cnt_q[7:0];
      ADDR_CNT_HI:   rd_mux[7:0] = cnt_q[15:8];
      ADDR_STATUS:
      begin
        rd_mux[STAT_GATE_BIT]  = gate_act;
        rd_mux[STAT_ARMED_BIT] = armed_q;
        rd_mux[STAT_RUN_BIT]   = count_en;
      end
      default:       rd_hit = 1'b0;
    endcase
  end

  // bus next state: one write and one read in flight at most
  always_comb
  begin
    awready_d = s_axi_awvalid && s_axi_wvalid && !awready_q && !bvalid_q;
    bvalid_d  = bvalid_q ? !s_axi_bready : awready_q;
    bresp_d   = bresp_q;
    if (awready_q)
    begin
      bresp_d = (s_axi_awaddr <= ADDR_CNT_HI && s_axi_awaddr[1:0] == 2'h0)
                ? RESP_OKAY : RESP_SLVERR; // status is read-only
    end
    arready_d = s_axi_arvalid && !arready_q && !rvalid_q;
    rvalid_d  = rvalid_q ? !s_axi_rready : arready_q;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (arready_q)
    begin
      rdata_d = rd_mux;
      rresp_d = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // bus registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= RESP_OKAY;
    end
    else
    begin
      awready_q <= awready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = awready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // decoded control fields
  assign on_bit    = ctrl_q[CTRL_ON_BIT];
  assign ge_bit    = ctrl_q[CTRL_GE_BIT];
  assign async_bit = ctrl_q[CTRL_ASYNC_BIT];
  // selects 14 and 15 have no source and keep the gate shut
  assign gate_act  = (gate_sel_q < 4'(GATE_SRCS))
                     && (sync_all[gate_sel_q] == ctrl_q[CTRL_GPOL_BIT]);
  assign count_en  = on_bit && (!ge_bit || gate_act);
  assign ext_rise  = ext_s && !ext_prev_q;
  assign ext_fall  = !ext_s && ext_prev_q;

  // prescale mask: the event passes when the low bits are all ones
  always_comb
  begin
    case (ctrl_q[CTRL_PS_LSB +: 2])
      2'h0:    ps_mask = 3'h0;
      2'h1:    ps_mask = 3'h1;
      2'h2:    ps_mask = 3'h3;
      default: ps_mask = 3'h7;
    endcase
  end

  // source events and timer next state
  always_comb
  begin
    ctrl_d     = ctrl_q;
    clk_sel_d  = clk_sel_q;
    gate_sel_d = gate_sel_q;
    ic_d       = ic_q + 2'h1;
    ext_prev_d = ext_s;
    armed_d    = armed_q;
    pend_d     = pend_q;
    src_tick   = 1'b0;
    // register writes other than the count
    if (wr_en && s_axi_awaddr == ADDR_CTRL)     ctrl_d     = s_axi_wdata[7:0];
    if (wr_en && s_axi_awaddr == ADDR_CLK_SEL)  clk_sel_d  = s_axi_wdata[3:0];
    if (wr_en && s_axi_awaddr == ADDR_GATE_SEL) gate_sel_d = s_axi_wdata[3:0];
    case (clk_sel_q)
      CS_FOSC4: src_tick = (ic_q == INSTR_LAST);
      CS_FOSC:  src_tick = 1'b1;
      CS_EXT:
      begin
        if (async_bit)
        begin
          src_tick = armed_q && ext_rise;
        end
        else
        begin
          // a synced edge waits for the next instruction boundary
          src_tick = pend_q && (ic_q == INSTR_LAST);
          if (src_tick)
          begin
            pend_d = 1'b0;
          end
          if (armed_q && ext_rise)
          begin
            pend_d = 1'b1;
          end
        end
        if (ext_fall)
        begin
          armed_d = 1'b1;
        end
      end
      default:  src_tick = 1'b0; // reserved codes stop the count
    endcase
    // disable forgets any fall; a count write too, unless a fall lands in that cycle
    if (!on_bit || cnt_wr)
    begin
      armed_d = on_bit && (clk_sel_q == CS_EXT) && ext_fall;
      pend_d  = 1'b0;
    end
    inc  = count_en && src_tick && ((ps_q & ps_mask) == ps_mask);
    ps_d = (count_en && src_tick) ? ps_q + 3'h1 : ps_q;
    cnt_d = inc ? cnt_q + 16'h0001 : cnt_q;
    // a write beats a same-cycle increment so software sees its value
    if (cnt_wr)
    begin
      ps_d = 3'h0;
    end
    if (wr_lo)
    begin
      cnt_d[7:0] = s_axi_wdata[7:0];
    end
    if (wr_hi)
    begin
      cnt_d[15:8] = s_axi_wdata[7:0];
    end
  end

  // timer registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q     <= CTRL_RST;
      clk_sel_q  <= CLK_SEL_RST;
      gate_sel_q <= GATE_SEL_RST;
      cnt_q      <= CNT_RST;
      ic_q       <= 2'h0;
      ps_q       <= 3'h0;
      ext_prev_q <= 1'b0;
      armed_q    <= 1'b0;
      pend_q     <= 1'b0;
    end
    else
    begin
      ctrl_q     <= ctrl_d;
      clk_sel_q  <= clk_sel_d;
      gate_sel_q <= gate_sel_d;
      cnt_q      <= cnt_d;
      ic_q       <= ic_d;
      ps_q       <= ps_d;
      ext_prev_q <= ext_prev_d;
      armed_q    <= armed_d;
      pend_q     <= pend_d;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_write_low_byte: assert property (
    wr_lo |=> cnt_q[7:0] == $past(s_axi_wdata[7:0]))
    else $error("low byte write not taken");
  a_write_high_byte: assert property (
    wr_hi |=> cnt_q[15:8] == $past(s_axi_wdata[7:0]))
    else $error("high byte write not taken");
  a_off_holds_count: assert property (
    (!on_bit && !cnt_wr) |=> $stable(cnt_q))
    else $error("count moved while off");
  a_instr_step_rate: assert property (
    (on_bit && !ge_bit && clk_sel_q == CS_FOSC4 && ps_mask == 3'h0 && !cnt_wr)
    |=> cnt_q == $past(cnt_q) + 16'($past(ic_q) == INSTR_LAST))
    else $error("instruction clock step wrong");
  a_fosc_four_per: assert property (
    (on_bit && !ge_bit && clk_sel_q == CS_FOSC && ps_mask == 3'h0 && !cnt_wr)[*5]
    |-> cnt_q == $past(cnt_q, 4) + 16'h0004)
    else $error("oscillator source not four per instruction");
  a_prescale_half: assert property (
    (on_bit && !ge_bit && clk_sel_q == CS_FOSC && ps_mask == 3'h1 && !cnt_wr)[*3]
    |-> cnt_q == $past(cnt_q, 2) + 16'h0001)
    else $error("divide by two prescale wrong");
  a_gate_closed_hold: assert property (
    (on_bit && ge_bit && !gate_act && !cnt_wr) |=> $stable(cnt_q))
    else $error("count moved with gate closed");
  a_unarmed_ignores: assert property (
    (clk_sel_q == CS_EXT && !armed_q && !pend_q && !cnt_wr) |=> $stable(cnt_q))
    else $error("edge counted before falling edge");
  a_async_rise_counts: assert property (
    (clk_sel_q == CS_EXT && async_bit && armed_q && ext_rise && count_en
     && ps_mask == 3'h0 && !cnt_wr) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("armed rising edge not counted");
  a_sync_waits_instr: assert property (
    (clk_sel_q == CS_EXT && !async_bit && ic_q != INSTR_LAST && !cnt_wr)
    |=> $stable(cnt_q))
    else $error("synced input counted off instruction boundary");
  a_write_answer: assert property (
    awready_q |=> bvalid_q)
    else $error("write answer missing");

  c_gated_count: cover property (on_bit && ge_bit && inc);
  c_ext_count: cover property (clk_sel_q == CS_EXT && inc);
  c_count_wrap: cover property (inc && cnt_q == 16'hFFFF);
  c_read_slverr: cover property (rvalid_q && rresp_q == RESP_SLVERR);
endmodule // gst_timer

// ### testbench/gst_timer_tb.sv
// self-checking testbench of the gated sixteen bit timer
`timescale 1ns/1ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module gst_timer_tb
  import gst_pkg::*;
();
  // expected read answer
  typedef struct {logic [31:0] d; logic [1:0] r; bit chk;} gst_exp_t;

  // clock, reset and bus
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  // all gate sources as one vector, and the external pin
  logic [13:0] gsrc;
  logic        external_count_input;
  // scoreboard and scratch
  gst_exp_t    rq[$];
  logic [1:0]  wq[$];
  gst_exp_t    e;
  int          n_fail = 0, n_tests = 0, cyc = 0, ex;
  logic [31:0] last_rd;
  logic [15:0] c1, c2, v;
  logic [13:0] m;

  gst_timer u_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .gate_pin(gsrc[0]), .timer_zero_output(gsrc[1]),
    .sibling_counter_output(gsrc[3:2]), .period_timer_output(gsrc[6:4]),
    .capture_compare_output(gsrc[8:7]), .pulse_width_output(gsrc[10:9]),
    .comparator_output(gsrc[12:11]), .zero_cross_output(gsrc[13]), .external_count_input
  );

  // 100 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // hang guard: the whole run needs well under this many cycles
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      n_fail++;
      $display("[ERR] %0t timeout", $time);
      summarize();
    end
  end

  // watcher: each answer taken off the bus is matched with the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      `CHK(s_axi_bresp, wq.pop_front())
    if (s_axi_rvalid && s_axi_rready)
    begin
      e = rq.pop_front();
      `CHK(s_axi_rresp, e.r)
      if (e.chk)
        `CHK(s_axi_rdata, e.d)
    end
  end

  // bus write; valids held until taken, bready until the response
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    wq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(negedge aclk); while (!(s_axi_awready && s_axi_wready));
    @(posedge aclk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  // bus read; chk low means only the response code is noted
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input bit chk = 1'b1,
                    input logic [1:0] r = RESP_OKAY);
    rq.push_back('{d, r, chk});
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    last_rd = s_axi_rdata;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // whole count; only used while stopped, since the bytes may tear
  task automatic rdcnt(output logic [15:0] c);
    rd(ADDR_CNT_LO, 32'h0, 1'b0);
    c[7:0] = last_rd[7:0];
    rd(ADDR_CNT_HI, 32'h0, 1'b0);
    c[15:8] = last_rd[7:0];
  endtask

  // external pin level, then time for the synchroniser to settle
  task automatic ext_set(input logic lvl);
    @(posedge aclk);
    external_count_input <= lvl;
    repeat (12) @(posedge aclk);
  endtask

  task automatic summarize();
    $display("counts: %0d checks, %0d mismatches", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    gsrc = 14'h0;
    external_count_input = 1'b0;
    void'($urandom(32'h29F8));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values and refused accesses
    rd(ADDR_CTRL, {24'h0, CTRL_RST});
    rd(ADDR_CLK_SEL, {28'h0, CLK_SEL_RST});
    rd(ADDR_GATE_SEL, {28'h0, GATE_SEL_RST});
    rd(ADDR_CNT_LO, {24'h0, CNT_RST[7:0]});
    rd(ADDR_CNT_HI, {24'h0, CNT_RST[15:8]});
    rd(8'h18, 32'h0, 1'b1, RESP_SLVERR);
    wr(ADDR_STATUS, 32'hFF, RESP_SLVERR);
    wr(8'h02, 32'hFF, RESP_SLVERR);
    rd(ADDR_STATUS, 32'(1 << STAT_GATE_BIT));
    $display("test reset done");
    // gate enable alone must not start the count
    wr(ADDR_CTRL, 32'h2);
    wr(ADDR_CLK_SEL, {28'h0, CS_FOSC});
    repeat (4)
    begin
      v = 16'($urandom);
      wr(ADDR_CNT_LO, {24'h0, v[7:0]});
      wr(ADDR_CNT_HI, {24'h0, v[15:8]});
      repeat (20) @(posedge aclk);
      rd(ADDR_CNT_LO, {24'h0, v[7:0]});
      rd(ADDR_CNT_HI, {24'h0, v[15:8]});
    end
    $display("test byte write done");
    // always-on timing, instruction clock and oscillator, every prescale
    for (int cs = 1; cs <= 2; cs++)
      for (int ps = 0; ps < 4; ps++)
      begin
        wr(ADDR_CTRL, 32'h0);
        wr(ADDR_CLK_SEL, 32'(cs));
        wr(ADDR_CNT_LO, 32'h0);
        wr(ADDR_CNT_HI, 32'h0);
        wr(ADDR_CTRL, 32'(1 + (ps << CTRL_PS_LSB)));
        repeat (400) @(posedge aclk);
        wr(ADDR_CTRL, 32'h0);
        rdcnt(c1);
        ex = ((cs == 2) ? 400 : 100) >> ps;
        `CHK(c1 + 6 >= ex && c1 <= ex + 6, 1'b1)
      end
    $display("test timing done");
    // gated counting from each source; codes 14 and 15 never open
    wr(ADDR_CLK_SEL, {28'h0, CS_FOSC});
    wr(ADDR_CTRL, 32'hB);
    for (int s = 0; s < 16; s++)
    begin
      m = 14'h1 << s;
      wr(ADDR_GATE_SEL, 32'(s));
      wr(ADDR_CNT_LO, 32'h0);
      wr(ADDR_CNT_HI, 32'h0);
      gsrc <= 14'($urandom) | m;
      repeat (60) @(posedge aclk);
      gsrc <= 14'($urandom) & ~m;
      repeat (10) @(posedge aclk);
      rdcnt(c1);
      repeat (40) @(posedge aclk);
      rdcnt(c2);
      `CHK((s < 14) ? (c1 >= 50 && c1 <= 75) : (c1 == 16'h0), 1'b1)
      `CHK(c2, c1)
    end
    $display("test gate done");
    // external edges, synchronised and free-running
    wr(ADDR_CLK_SEL, {28'h0, CS_EXT});
    for (int a = 0; a < 2; a++)
    begin
      wr(ADDR_CTRL, 32'h0);
      ext_set(1'b0);
      wr(ADDR_CNT_LO, 32'h0);
      wr(ADDR_CNT_HI, 32'h0);
      wr(ADDR_CTRL, 32'(1 + (a << CTRL_ASYNC_BIT)));
      ext_set(1'b1);
      rd(ADDR_CNT_LO, 32'h0);
      for (int k = 1; k <= 4; k++)
      begin
        ext_set(1'b0);
        rd(ADDR_STATUS, 32'((1 << STAT_ARMED_BIT) | (1 << STAT_RUN_BIT)));
        ext_set(1'b1);
        rd(ADDR_CNT_LO, 32'(k));
      end
      ext_set(1'b0);
      wr(ADDR_CNT_LO, 32'h10);
      ext_set(1'b1);
      rd(ADDR_CNT_LO, 32'h10);
      ext_set(1'b0);
      ext_set(1'b1);
      rd(ADDR_CNT_LO, 32'h11);
    end
    $display("test external done");
    summarize();
  end
endmodule // gst_timer_tb
